/* rtl/arith_decode_pkg.sv */
package arith_decode_pkg;

  typedef enum logic [3:0] {
    op_none,
    op_seg_override,
    op_sum,
    op_sum_carry,
    op_diff,
    op_diff_borrow,
    op_plus_one,
    op_minus_one,
    op_compare,
    op_sign_flip,
    op_ascii_sum,
    op_bcd_sum,
    op_ascii_diff,
    op_bcd_diff,
    op_unsigned_product
  } op_type;

  typedef enum logic [2:0] {
    form_single,
    form_rm_reg,
    form_imm_rm,
    form_imm_acc,
    form_rm,
    form_short_reg
  } form_type;

  // Opcode patterns, compared after masking, except the four fixup opcodes, which are compared whole
  localparam logic [7:0] MASK_SEG = 8'hE7;
  localparam logic [7:0] OPC_SEG = 8'h26;
  localparam logic [7:0] MASK_RM_REG = 8'hFC;
  localparam logic [7:0] OPC_SUM_RM = 8'h00;
  localparam logic [7:0] OPC_CARRY_RM = 8'h10;
  localparam logic [7:0] OPC_BORROW_RM = 8'h18;
  localparam logic [7:0] OPC_DIFF_RM = 8'h28;
  localparam logic [7:0] OPC_CMP_RM = 8'h38;
  localparam logic [7:0] MASK_ACC = 8'hFE;
  localparam logic [7:0] OPC_SUM_ACC = 8'h04;
  localparam logic [7:0] OPC_CARRY_ACC = 8'h14;
  localparam logic [7:0] OPC_BORROW_ACC = 8'h1C;
  localparam logic [7:0] OPC_DIFF_ACC = 8'h2C;
  localparam logic [7:0] OPC_CMP_ACC = 8'h3C;
  localparam logic [7:0] MASK_IMM_GRP = 8'hFC;
  localparam logic [7:0] OPC_IMM_GRP = 8'h80;
  localparam logic [7:0] MASK_UNARY = 8'hFE;
  localparam logic [7:0] OPC_UNARY_GRP = 8'hF6;
  localparam logic [7:0] OPC_STEP_GRP = 8'hFE;
  localparam logic [7:0] MASK_SHORT = 8'hF8;
  localparam logic [7:0] OPC_INC_SHORT = 8'h40;
  localparam logic [7:0] OPC_DEC_SHORT = 8'h48;
  localparam logic [7:0] OPC_ASCII_SUM = 8'h37;
  localparam logic [7:0] OPC_BCD_SUM = 8'h27;
  localparam logic [7:0] OPC_ASCII_DIFF = 8'h3F;
  localparam logic [7:0] OPC_BCD_DIFF = 8'h2F;

  // Sub-codes in the middle field of the second byte
  localparam logic [2:0] SUB_SUM = 3'h0;
  localparam logic [2:0] SUB_CARRY = 3'h2;
  localparam logic [2:0] SUB_BORROW = 3'h3;
  localparam logic [2:0] SUB_DIFF = 3'h5;
  localparam logic [2:0] SUB_CMP = 3'h7;
  localparam logic [2:0] SUB_PLUS = 3'h0;
  localparam logic [2:0] SUB_MINUS = 3'h1;
  localparam logic [2:0] SUB_SIGN = 3'h3;
  localparam logic [2:0] SUB_PRODUCT = 3'h4;

  localparam logic [1:0] MOD_NO_DISP = 2'h0;
  localparam logic [1:0] MOD_DISP8 = 2'h1;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam logic [2:0] RM_DIRECT = 3'h6;

  // Execution clock counts
  localparam logic [5:0] CLK_PREFIX = 6'h02;
  localparam logic [5:0] CLK_ALU_REG = 6'h03;
  localparam logic [5:0] CLK_ALU_MEM = 6'h0A;
  localparam logic [5:0] CLK_IMM_REG = 6'h04;
  localparam logic [5:0] CLK_IMM_MEM = 6'h10;
  localparam logic [5:0] CLK_ACC_BYTE = 6'h03;
  localparam logic [5:0] CLK_ACC_WORD = 6'h04;
  localparam logic [5:0] CLK_STEP_MEM = 6'h0F;
  localparam logic [5:0] CLK_ASCII_SUM = 6'h08;
  localparam logic [5:0] CLK_BCD_SUM = 6'h04;
  localparam logic [5:0] CLK_ASCII_DIFF = 6'h07;
  localparam logic [5:0] CLK_BCD_DIFF = 6'h04;
  localparam logic [5:0] CLK_MUL_REG_BYTE = 6'h1A;
  localparam logic [5:0] CLK_MUL_REG_WORD = 6'h23;
  localparam logic [5:0] CLK_MUL_MEM_BYTE = 6'h20;
  localparam logic [5:0] CLK_MUL_MEM_WORD = 6'h29;
  localparam logic [1:0] MUL_EXTRA_MAX = 2'h2;
  localparam logic [5:0] CLK_NARROW_XFER = 6'h04;

endpackage

/* rtl/opcode_classifier.sv */
`timescale 1ns/1ps
module opcode_classifier (
  input wire logic [7:0] i_opcode,
  input wire logic [2:0] i_sub,
  output arith_decode_pkg::op_type o_op,
  output arith_decode_pkg::form_type o_form,
  output logic o_has_modrm,
  output logic o_known
);

  function automatic logic hit(input logic [7:0] b, input logic [7:0] m, input logic [7:0] p);
    hit = (b & m) == p;
  endfunction

  always_comb begin
    o_op = arith_decode_pkg::op_none;
    o_form = arith_decode_pkg::form_single;
    o_has_modrm = 1'b0;
    if (hit(i_opcode, arith_decode_pkg::MASK_SEG, arith_decode_pkg::OPC_SEG)) begin
      o_op = arith_decode_pkg::op_seg_override;
    end else if (i_opcode == arith_decode_pkg::OPC_ASCII_SUM) begin
      o_op = arith_decode_pkg::op_ascii_sum;
    end else if (i_opcode == arith_decode_pkg::OPC_BCD_SUM) begin
      o_op = arith_decode_pkg::op_bcd_sum;
    end else if (i_opcode == arith_decode_pkg::OPC_ASCII_DIFF) begin
      o_op = arith_decode_pkg::op_ascii_diff;
    end else if (i_opcode == arith_decode_pkg::OPC_BCD_DIFF) begin
      o_op = arith_decode_pkg::op_bcd_diff;
    end else if (hit(i_opcode, arith_decode_pkg::MASK_SHORT,
                     arith_decode_pkg::OPC_INC_SHORT)) begin
      o_op = arith_decode_pkg::op_plus_one;
      o_form = arith_decode_pkg::form_short_reg;
    end else if (hit(i_opcode, arith_decode_pkg::MASK_SHORT,
                     arith_decode_pkg::OPC_DEC_SHORT)) begin
      o_op = arith_decode_pkg::op_minus_one;
      o_form = arith_decode_pkg::form_short_reg;
    end else if ((i_opcode & arith_decode_pkg::MASK_RM_REG) == arith_decode_pkg::OPC_SUM_RM) begin
      o_op = arith_decode_pkg::op_sum;
      o_form = arith_decode_pkg::form_rm_reg;
      o_has_modrm = 1'b1;
    end else if ((i_opcode & arith_decode_pkg::MASK_RM_REG) ==
                 arith_decode_pkg::OPC_CARRY_RM) begin
      o_op = arith_decode_pkg::op_sum_carry;
      o_form = arith_decode_pkg::form_rm_reg;
      o_has_modrm = 1'b1;
    end else if ((i_opcode & arith_decode_pkg::MASK_RM_REG) == arith_decode_pkg::OPC_DIFF_RM) begin
      o_op = arith_decode_pkg::op_diff;
      o_form = arith_decode_pkg::form_rm_reg;
      o_has_modrm = 1'b1;
    end else if ((i_opcode & arith_decode_pkg::MASK_RM_REG) ==
                 arith_decode_pkg::OPC_BORROW_RM) begin
      o_op = arith_decode_pkg::op_diff_borrow;
      o_form = arith_decode_pkg::form_rm_reg;
      o_has_modrm = 1'b1;
    end else if ((i_opcode & arith_decode_pkg::MASK_RM_REG) == arith_decode_pkg::OPC_CMP_RM) begin
      o_op = arith_decode_pkg::op_compare;
      o_form = arith_decode_pkg::form_rm_reg;
      o_has_modrm = 1'b1;
    end else if ((i_opcode & arith_decode_pkg::MASK_ACC) == arith_decode_pkg::OPC_SUM_ACC) begin
      o_op = arith_decode_pkg::op_sum;
      o_form = arith_decode_pkg::form_imm_acc;
    end else if ((i_opcode & arith_decode_pkg::MASK_ACC) == arith_decode_pkg::OPC_CARRY_ACC) begin
      o_op = arith_decode_pkg::op_sum_carry;
      o_form = arith_decode_pkg::form_imm_acc;
    end else if ((i_opcode & arith_decode_pkg::MASK_ACC) == arith_decode_pkg::OPC_DIFF_ACC) begin
      o_op = arith_decode_pkg::op_diff;
      o_form = arith_decode_pkg::form_imm_acc;
    end else if ((i_opcode & arith_decode_pkg::MASK_ACC) == arith_decode_pkg::OPC_BORROW_ACC) begin
      o_op = arith_decode_pkg::op_diff_borrow;
      o_form = arith_decode_pkg::form_imm_acc;
    end else if ((i_opcode & arith_decode_pkg::MASK_ACC) == arith_decode_pkg::OPC_CMP_ACC) begin
      o_op = arith_decode_pkg::op_compare;
      o_form = arith_decode_pkg::form_imm_acc;
    end else if ((i_opcode & arith_decode_pkg::MASK_IMM_GRP) ==
                 arith_decode_pkg::OPC_IMM_GRP) begin
      o_form = arith_decode_pkg::form_imm_rm;
      o_has_modrm = 1'b1;
      if (i_sub == arith_decode_pkg::SUB_SUM) begin
        o_op = arith_decode_pkg::op_sum;
      end else if (i_sub == arith_decode_pkg::SUB_CARRY) begin
        o_op = arith_decode_pkg::op_sum_carry;
      end else if (i_sub == arith_decode_pkg::SUB_DIFF) begin
        o_op = arith_decode_pkg::op_diff;
      end else if (i_sub == arith_decode_pkg::SUB_BORROW) begin
        o_op = arith_decode_pkg::op_diff_borrow;
      end else if (i_sub == arith_decode_pkg::SUB_CMP) begin
        o_op = arith_decode_pkg::op_compare;
      end
    end else if ((i_opcode & arith_decode_pkg::MASK_UNARY) ==
                 arith_decode_pkg::OPC_UNARY_GRP) begin
      o_form = arith_decode_pkg::form_rm;
      o_has_modrm = 1'b1;
      if (i_sub == arith_decode_pkg::SUB_SIGN) begin
        o_op = arith_decode_pkg::op_sign_flip;
      end else if (i_sub == arith_decode_pkg::SUB_PRODUCT) begin
        o_op = arith_decode_pkg::op_unsigned_product;
      end
    end else if ((i_opcode & arith_decode_pkg::MASK_UNARY) == arith_decode_pkg::OPC_STEP_GRP) begin
      o_form = arith_decode_pkg::form_rm;
      o_has_modrm = 1'b1;
      if (i_sub == arith_decode_pkg::SUB_PLUS) begin
        o_op = arith_decode_pkg::op_plus_one;
      end else if (i_sub == arith_decode_pkg::SUB_MINUS) begin
        o_op = arith_decode_pkg::op_minus_one;
      end
    end
    o_known = o_op != arith_decode_pkg::op_none;
  end

endmodule

/* rtl/arith_opcode_decoder.sv */
`timescale 1ns/1ps
module arith_opcode_decoder (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  input wire logic i_narrow_bus,
  input wire logic [1:0] i_mul_extra,
  output logic o_byte_ready,
  output logic o_op_valid,
  output arith_decode_pkg::op_type o_op,
  output arith_decode_pkg::form_type o_form,
  output logic o_word,
  output logic o_to_reg,
  output logic o_mem,
  output logic [1:0] o_mod,
  output logic [2:0] o_reg,
  output logic [2:0] o_rm,
  output logic [15:0] o_disp,
  output logic [15:0] o_imm,
  output logic [5:0] o_clocks,
  output logic o_busy,
  output logic o_done,
  output logic o_unknown,
  output logic o_seg_valid,
  output logic [1:0] o_seg_code
);

  typedef enum logic [2:0] {
    st_opcode, st_modrm, st_disp_lo, st_disp_hi, st_imm_lo, st_imm_hi, st_exec
  } state_type;

  state_type state, next_state;
  logic [7:0] opcode, next_opcode;
  logic [7:0] modrm, next_modrm;
  logic [1:0] disp_len, next_disp_len;
  logic [1:0] imm_len, next_imm_len;
  logic [5:0] count, next_count;
  logic is_prefix, next_is_prefix;
  logic next_op_valid, next_word, next_to_reg, next_mem, next_done, next_unknown;
  logic next_seg_valid;
  logic [1:0] next_seg_code;
  logic [15:0] next_disp, next_imm;
  logic [5:0] next_clocks;
  arith_decode_pkg::op_type next_op;
  arith_decode_pkg::form_type next_form;
  logic [7:0] cls_opcode;
  logic [2:0] cls_sub;
  arith_decode_pkg::op_type cls_op;
  arith_decode_pkg::form_type cls_form;
  logic cls_has_modrm, cls_known;
  logic take;

  assign take = i_byte_valid && o_byte_ready;
  assign cls_opcode = (state == st_opcode) ? i_byte : opcode;
  assign cls_sub = (state == st_modrm) ? i_byte[5:3] : modrm[5:3];

  opcode_classifier u_classifier (
    .i_opcode(cls_opcode),
    .i_sub(cls_sub),
    .o_op(cls_op),
    .o_form(cls_form),
    .o_has_modrm(cls_has_modrm),
    .o_known(cls_known)
  );

  // Destination written back to memory means a read and a write transfer
  function automatic logic two_transfers(input arith_decode_pkg::op_type op,
                                         input arith_decode_pkg::form_type f,
                                         input logic to_reg);
    two_transfers = (op != arith_decode_pkg::op_compare) &&
                    (op != arith_decode_pkg::op_unsigned_product) &&
                    !(f == arith_decode_pkg::form_rm_reg && to_reg);
  endfunction

  function automatic logic [5:0] op_cost(input arith_decode_pkg::op_type op,
                                         input arith_decode_pkg::form_type f,
                                         input logic mem, input logic wide,
                                         input logic narrow, input logic rmw,
                                         input logic [1:0] extra);
    logic [5:0] c;
    c = arith_decode_pkg::CLK_ALU_REG;
    case (op)
      arith_decode_pkg::op_seg_override: c = arith_decode_pkg::CLK_PREFIX;
      arith_decode_pkg::op_ascii_sum: c = arith_decode_pkg::CLK_ASCII_SUM;
      arith_decode_pkg::op_bcd_sum: c = arith_decode_pkg::CLK_BCD_SUM;
      arith_decode_pkg::op_ascii_diff: c = arith_decode_pkg::CLK_ASCII_DIFF;
      arith_decode_pkg::op_bcd_diff: c = arith_decode_pkg::CLK_BCD_DIFF;
      arith_decode_pkg::op_unsigned_product: begin
        if (mem) begin
          c = wide ? arith_decode_pkg::CLK_MUL_MEM_WORD : arith_decode_pkg::CLK_MUL_MEM_BYTE;
        end else begin
          c = wide ? arith_decode_pkg::CLK_MUL_REG_WORD : arith_decode_pkg::CLK_MUL_REG_BYTE;
        end
        // Data-dependent tail clamped to the documented range
        if (extra > arith_decode_pkg::MUL_EXTRA_MAX) begin
          c = c + {4'h0, arith_decode_pkg::MUL_EXTRA_MAX};
        end else begin
          c = c + {4'h0, extra};
        end
      end
      default: begin
        if (f == arith_decode_pkg::form_imm_acc) begin
          c = wide ? arith_decode_pkg::CLK_ACC_WORD : arith_decode_pkg::CLK_ACC_BYTE;
        end else if (f == arith_decode_pkg::form_imm_rm &&
                     op != arith_decode_pkg::op_compare) begin
          c = mem ? arith_decode_pkg::CLK_IMM_MEM : arith_decode_pkg::CLK_IMM_REG;
        end else if (op == arith_decode_pkg::op_plus_one ||
                     op == arith_decode_pkg::op_minus_one) begin
          c = mem ? arith_decode_pkg::CLK_STEP_MEM : arith_decode_pkg::CLK_ALU_REG;
        end else begin
          c = mem ? arith_decode_pkg::CLK_ALU_MEM : arith_decode_pkg::CLK_ALU_REG;
        end
      end
    endcase
    if (narrow && wide && mem) begin
      c = c + arith_decode_pkg::CLK_NARROW_XFER;
      if (rmw) begin
        c = c + arith_decode_pkg::CLK_NARROW_XFER;
      end
    end
    op_cost = c;
  endfunction

  always_comb begin
    logic launch;
    logic [5:0] cost;
    launch = 1'b0;
    cost = arith_decode_pkg::CLK_PREFIX;
    next_state = state;
    next_opcode = opcode;
    next_modrm = modrm;
    next_disp_len = disp_len;
    next_imm_len = imm_len;
    next_count = count;
    next_is_prefix = is_prefix;
    next_op_valid = 1'b0;
    next_done = 1'b0;
    next_unknown = 1'b0;
    next_op = o_op;
    next_form = o_form;
    next_word = o_word;
    next_to_reg = o_to_reg;
    next_mem = o_mem;
    next_disp = o_disp;
    next_imm = o_imm;
    next_clocks = o_clocks;
    next_seg_valid = o_seg_valid;
    next_seg_code = o_seg_code;
    case (state)
      st_opcode: begin
        if (take) begin
          next_opcode = i_byte;
          next_modrm = '0;
          next_disp = '0;
          next_imm = '0;
          next_disp_len = '0;
          next_imm_len = {1'b0, 1'b1} + {1'b0, i_byte[0]};
          if (!cls_known && !cls_has_modrm) begin
            next_unknown = 1'b1;
          end else if (cls_has_modrm) begin
            next_state = st_modrm;
          end else if (cls_form == arith_decode_pkg::form_imm_acc) begin
            next_state = st_imm_lo;
          end else begin
            launch = 1'b1;
          end
        end
      end
      st_modrm: begin
        if (take) begin
          next_modrm = i_byte;
          if (i_byte[7:6] == arith_decode_pkg::MOD_DISP8) begin
            next_disp_len = 2'h1;
          end else if (i_byte[7:6] == arith_decode_pkg::MOD_REG) begin
            next_disp_len = 2'h0;
          end else if (i_byte[7:6] == arith_decode_pkg::MOD_NO_DISP) begin
            next_disp_len = (i_byte[2:0] == arith_decode_pkg::RM_DIRECT) ? 2'h2 : 2'h0;
          end else begin
            next_disp_len = 2'h2;
          end
          // Sign-extended byte immediate when s w = 11
          next_imm_len = (opcode[1:0] == 2'h1) ? 2'h2 : 2'h1;
          if (cls_form != arith_decode_pkg::form_imm_rm) begin
            next_imm_len = 2'h0;
          end
          if (!cls_known) begin
            next_unknown = 1'b1;
            next_state = st_opcode;
          end else if (next_disp_len != 2'h0) begin
            next_state = st_disp_lo;
          end else if (next_imm_len != 2'h0) begin
            next_state = st_imm_lo;
          end else begin
            launch = 1'b1;
          end
        end
      end
      st_disp_lo: begin
        if (take) begin
          next_disp = {{8{i_byte[7]}}, i_byte};
          if (disp_len == 2'h2) begin
            next_state = st_disp_hi;
          end else if (imm_len != 2'h0) begin
            next_state = st_imm_lo;
          end else begin
            launch = 1'b1;
          end
        end
      end
      st_disp_hi: begin
        if (take) begin
          next_disp = {i_byte, o_disp[7:0]};
          if (imm_len != 2'h0) begin
            next_state = st_imm_lo;
          end else begin
            launch = 1'b1;
          end
        end
      end
      st_imm_lo: begin
        if (take) begin
          next_imm = {8'h00, i_byte};
          if (cls_form == arith_decode_pkg::form_imm_rm && opcode[1:0] == 2'h3) begin
            next_imm = {{8{i_byte[7]}}, i_byte};
          end
          if (imm_len == 2'h2) begin
            next_state = st_imm_hi;
          end else begin
            launch = 1'b1;
          end
        end
      end
      st_imm_hi: begin
        if (take) begin
          next_imm = {i_byte, o_imm[7:0]};
          launch = 1'b1;
        end
      end
      default: begin
        if (count == 6'h00) begin
          next_done = 1'b1;
          next_state = st_opcode;
          // Override is spent once the following instruction retires
          if (!is_prefix) begin
            next_seg_valid = 1'b0;
          end
        end else begin
          next_count = count - 6'h01;
        end
      end
    endcase
    if (launch) begin
      next_op = cls_op;
      next_form = cls_form;
      next_word = next_opcode[0] && cls_form != arith_decode_pkg::form_short_reg &&
                  cls_form != arith_decode_pkg::form_single;
      next_to_reg = (cls_form == arith_decode_pkg::form_rm_reg) && next_opcode[1];
      next_mem = cls_has_modrm && next_modrm[7:6] != arith_decode_pkg::MOD_REG;
      next_is_prefix = cls_op == arith_decode_pkg::op_seg_override;
      if (next_is_prefix) begin
        next_seg_valid = 1'b1;
        next_seg_code = next_opcode[4:3];
      end
      cost = op_cost(cls_op, cls_form, next_mem, next_word, i_narrow_bus,
                     two_transfers(cls_op, cls_form, next_to_reg), i_mul_extra);
      next_clocks = cost;
      next_count = cost - 6'h01;
      next_op_valid = 1'b1;
      next_state = st_exec;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= st_opcode;
      opcode <= '0;
      modrm <= '0;
      disp_len <= '0;
      imm_len <= '0;
      count <= '0;
      is_prefix <= 1'b0;
      o_byte_ready <= 1'b0;
      o_op_valid <= 1'b0;
      o_op <= arith_decode_pkg::op_none;
      o_form <= arith_decode_pkg::form_single;
      o_word <= 1'b0;
      o_to_reg <= 1'b0;
      o_mem <= 1'b0;
      o_mod <= '0;
      o_reg <= '0;
      o_rm <= '0;
      o_disp <= '0;
      o_imm <= '0;
      o_clocks <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_unknown <= 1'b0;
      o_seg_valid <= 1'b0;
      o_seg_code <= '0;
    end else begin
      state <= next_state;
      opcode <= next_opcode;
      modrm <= next_modrm;
      disp_len <= next_disp_len;
      imm_len <= next_imm_len;
      count <= next_count;
      is_prefix <= next_is_prefix;
      o_byte_ready <= next_state != st_exec;
      o_op_valid <= next_op_valid;
      o_op <= next_op;
      o_form <= next_form;
      o_word <= next_word;
      o_to_reg <= next_to_reg;
      o_mem <= next_mem;
      o_mod <= next_modrm[7:6];
      o_reg <= (next_form == arith_decode_pkg::form_short_reg) ?
               next_opcode[2:0] : next_modrm[5:3];
      o_rm <= next_modrm[2:0];
      o_disp <= next_disp;
      o_imm <= next_imm;
      o_clocks <= next_clocks;
      o_busy <= next_state == st_exec;
      o_done <= next_done;
      o_unknown <= next_unknown;
      o_seg_valid <= next_seg_valid;
      o_seg_code <= next_seg_code;
    end
  end

endmodule

/* dv/prefetch_queue_model.sv */
`timescale 1ns/1ps
module prefetch_queue_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ready,
  input wire logic i_slow,
  output logic o_valid,
  output logic [7:0] o_byte
);
  logic [7:0] q[$];
  int rd;
  logic go;
  function automatic void push(input logic [7:0] b);
    q.push_back(b);
  endfunction
  // An idle line toggles, so a stale byte never reads as a fresh one
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd = 0;
      o_valid <= 1'b0;
      o_byte <= 8'h00;
    end else if (!o_valid || i_ready) begin
      if (o_valid) rd = rd + 1;
      go = rd < q.size() && !(i_slow && o_valid);
      o_valid <= go;
      o_byte <= go ? q[rd] : ~o_byte;
    end
  end
endmodule

/* dv/arith_opcode_decoder_assertions.sv */
`timescale 1ns/1ps
module arith_opcode_decoder_assertions (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic o_byte_ready,
  input wire logic o_op_valid,
  input wire arith_decode_pkg::op_type o_op,
  input wire arith_decode_pkg::form_type o_form,
  input wire logic o_word,
  input wire logic o_mem,
  input wire logic [5:0] o_clocks,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_seg_valid
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [5:0] cnt;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) cnt <= 6'h00;
    else if (o_op_valid) cnt <= 6'h01;
    else if (o_busy) cnt <= cnt + 6'h01;
  end
  chk_prefix_cost: assert property (o_op_valid && o_op == arith_decode_pkg::op_seg_override
    |-> o_clocks == 6'h02 && o_seg_valid) else $error("prefix cost wrong");
  chk_busy_span: assert property ($fell(o_busy) |-> cnt == o_clocks && o_done)
    else $error("busy span differs from cost");
  chk_done_ready: assert property (o_done |-> o_byte_ready && !o_busy ##1 !o_done)
    else $error("done without ready");
  chk_sign_reg: assert property (o_op_valid && o_op == arith_decode_pkg::op_sign_flip
    && !o_mem |-> o_clocks == 6'h03) else $error("sign flip cost wrong");
  chk_ascii_sum: assert property (o_op_valid && o_op == arith_decode_pkg::op_ascii_sum
    |-> o_clocks == 6'h08) else $error("ascii sum cost wrong");
  chk_bcd_cost: assert property (o_op_valid
    && (o_op == arith_decode_pkg::op_bcd_sum || o_op == arith_decode_pkg::op_bcd_diff)
    |-> o_clocks == 6'h04) else $error("bcd cost wrong");
  chk_ascii_diff: assert property (o_op_valid && o_op == arith_decode_pkg::op_ascii_diff
    |-> o_clocks == 6'h07) else $error("ascii diff cost wrong");
  chk_product_reg: assert property (o_op_valid
    && o_op == arith_decode_pkg::op_unsigned_product
    && !o_mem && !o_word |-> o_clocks inside {[26:28]}) else $error("product cost wrong");
  chk_short_form: assert property (o_op_valid && o_form == arith_decode_pkg::form_short_reg
    |-> o_clocks == 6'h03 && !o_word) else $error("short form wrong");
  chk_cmp_acc: assert property (o_op_valid && o_op == arith_decode_pkg::op_compare
    && o_form == arith_decode_pkg::form_imm_acc |-> o_clocks == (o_word ? 6'h04 : 6'h03))
    else $error("compare cost wrong");
endmodule
bind arith_opcode_decoder arith_opcode_decoder_assertions i_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .o_byte_ready(o_byte_ready), .o_op_valid(o_op_valid), .o_op(o_op), .o_form(o_form),
  .o_word(o_word), .o_mem(o_mem), .o_clocks(o_clocks), .o_busy(o_busy), .o_done(o_done),
  .o_seg_valid(o_seg_valid));

/* dv/arith_opcode_decoder_tb.sv */
`timescale 1ns/1ps
module arith_opcode_decoder_tb;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_narrow_bus = 1'b0;
  logic [1:0] i_mul_extra = 2'h0;
  logic slow = 1'b0;
  logic bv, o_byte_ready, o_op_valid, o_word, o_mem, o_busy, o_done, o_unknown, o_seg_valid;
  logic [7:0] bd;
  logic [1:0] o_seg_code, o_mod;
  logic [2:0] o_reg, o_rm;
  logic o_to_reg;
  logic [5:0] o_clocks;
  logic [15:0] o_imm, o_disp;
  arith_decode_pkg::op_type o_op;
  arith_decode_pkg::form_type o_form;
  int n_mismatch = 0;
  int n_checks = 0;
  always #12.5 i_clk = ~i_clk;
  prefetch_queue_model i_pq (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ready(o_byte_ready),
    .i_slow(slow), .o_valid(bv), .o_byte(bd));
  arith_opcode_decoder i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_byte_valid(bv), .i_byte(bd),
    .i_narrow_bus(i_narrow_bus), .i_mul_extra(i_mul_extra), .o_byte_ready(o_byte_ready),
    .o_op_valid(o_op_valid), .o_op(o_op), .o_form(o_form), .o_word(o_word), .o_to_reg(o_to_reg),
    .o_mem(o_mem), .o_mod(o_mod), .o_reg(o_reg), .o_rm(o_rm), .o_disp(o_disp), .o_imm(o_imm),
    .o_clocks(o_clocks), .o_busy(o_busy),
    .o_done(o_done), .o_unknown(o_unknown), .o_seg_valid(o_seg_valid), .o_seg_code(o_seg_code));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic run(input logic [7:0] b[$]);
    int k;
    #1;
    foreach (b[i]) i_pq.push(b[i]);
    for (k = 0; k < 200 && !(o_op_valid || o_unknown); k++) begin
      @(posedge i_clk);
      #1;
    end
  endtask
  task automatic op(input logic [7:0] b[$], input arith_decode_pkg::op_type p,
                    input logic [5:0] c);
    int k;
    run(b);
    check(16'(o_op), 16'(p));
    check(16'(o_clocks), 16'(c));
    for (k = 0; k < 80 && o_done !== 1'b1; k++) begin
      @(posedge i_clk);
      #1;
    end
    check(16'(o_done), 16'h0001);
  endtask
  task automatic t_prefix;
    logic [7:0] pre[4] = '{8'h26, 8'h2E, 8'h36, 8'h3E};
    for (int i = 0; i < 4; i++) begin
      op({pre[i]}, arith_decode_pkg::op_seg_override, 6'h02);
      check(16'({o_seg_valid, o_seg_code}), 16'(4 + i));
    end
    $display("prefix test done");
  endtask
  task automatic t_sum_diff;
    @(posedge i_clk) slow <= 1'b1;
    op({8'h01, 8'hC3}, arith_decode_pkg::op_sum, 6'h03);
    check(16'(o_seg_valid), 16'h0000);
    op({8'h81, 8'h06, 8'h34, 8'h12, 8'h78, 8'h56}, arith_decode_pkg::op_sum, 6'h10);
    check(o_imm, 16'h5678);
    check(o_disp, 16'h1234);
    op({8'h05, 8'h34, 8'h12}, arith_decode_pkg::op_sum, 6'h04);
    @(posedge i_clk) slow <= 1'b0;
    op({8'h10, 8'hC0}, arith_decode_pkg::op_sum_carry, 6'h03);
    op({8'h80, 8'hD0, 8'h05}, arith_decode_pkg::op_sum_carry, 6'h04);
    op({8'h2C, 8'h05}, arith_decode_pkg::op_diff, 6'h03);
    op({8'h83, 8'hE8, 8'hFF}, arith_decode_pkg::op_diff, 6'h04);
    check(o_imm, 16'hFFFF);
    op({8'h1D, 8'h34, 8'h12}, arith_decode_pkg::op_diff_borrow, 6'h04);
    op({8'h19, 8'h47, 8'h10}, arith_decode_pkg::op_diff_borrow, 6'h0A);
    check(o_disp, 16'h0010);
    check(16'({o_mod, o_reg, o_rm}), 16'h0047);
    $display("sum and difference test done");
  endtask
  task automatic t_unary;
    op({8'hF6, 8'hD8}, arith_decode_pkg::op_sign_flip, 6'h03);
    op({8'hF7, 8'h5E, 8'h02}, arith_decode_pkg::op_sign_flip, 6'h0A);
    @(posedge i_clk) i_mul_extra <= 2'h2;
    op({8'hF6, 8'hE0}, arith_decode_pkg::op_unsigned_product, 6'h1C);
    @(posedge i_clk) i_mul_extra <= 2'h3;
    op({8'hF7, 8'h26, 8'h00, 8'h10}, arith_decode_pkg::op_unsigned_product, 6'h2B);
    run({8'hF7, 8'hF0});
    check(16'(o_unknown), 16'h0001);
    @(posedge i_clk);
    op({8'hFF, 8'hC0}, arith_decode_pkg::op_plus_one, 6'h03);
    op({8'hFE, 8'h06, 8'h00, 8'h20}, arith_decode_pkg::op_plus_one, 6'h0F);
    op({8'h4B}, arith_decode_pkg::op_minus_one, 6'h03);
    check(16'(o_reg), 16'h0003);
    op({8'h3C, 8'h05}, arith_decode_pkg::op_compare, 6'h03);
    check(16'(o_form), 16'(arith_decode_pkg::form_imm_acc));
    op({8'h83, 8'hF8, 8'h01}, arith_decode_pkg::op_compare, 6'h03);
    $display("unary and step test done");
  endtask
  task automatic t_fixup_narrow;
    logic [7:0] opc[4] = '{8'h37, 8'h27, 8'h3F, 8'h2F};
    logic [5:0] cyc[4] = '{6'h08, 6'h04, 6'h07, 6'h04};
    arith_decode_pkg::op_type ops[4] = '{arith_decode_pkg::op_ascii_sum,
      arith_decode_pkg::op_bcd_sum, arith_decode_pkg::op_ascii_diff,
      arith_decode_pkg::op_bcd_diff};
    for (int nb = 0; nb < 2; nb++) begin
      @(posedge i_clk) i_narrow_bus <= nb[0];
      for (int i = 0; i < 4; i++) op({opc[i]}, ops[i], cyc[i]);
    end
    op({8'h01, 8'h07}, arith_decode_pkg::op_sum, 6'h12);
    op({8'h00, 8'h07}, arith_decode_pkg::op_sum, 6'h0A);
    op({8'h3B, 8'h07}, arith_decode_pkg::op_compare, 6'h0E);
    check(16'({o_to_reg, o_word}), 16'h0003);
    @(posedge i_clk) i_narrow_bus <= 1'b0;
    $display("fixup and narrow bus test done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #2000000;
    n_mismatch++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    t_prefix();
    t_sum_diff();
    t_unary();
    t_fixup_narrow();
    final_report();
  end
endmodule
